// *** src/pfd_top.sv ***
// first-stage pll reference predivider and feedback dividers
// assumes reference and vcxo clocks are far slower than the core
// clock and arrive asynchronously on pins
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "pfd_consts.svh"
module pfd_top (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic i_ref_clk,
   input wire logic i_vcxo_clk,
   output logic o_ref_div_pulse,
   output logic o_fb_div_pulse,
   output logic o_lock_sample,
   output logic o_lock_in_window
);
   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   pfd_pkg::pfd_div12_t fb_div_primary_ff; // primary ratio
   pfd_pkg::pfd_div9_t fb_div_secondary_ff; // secondary ratio
   pfd_pkg::pfd_div12_t ref_predivider_ff; // reference ratio
   pfd_pkg::pfd_phase_t feedback_phase_sel_ff; // feedback window
   pfd_pkg::pfd_phase_t ref_phase_sel_ff; // reference window
   logic fb_secondary_powerdown_ff; // secondary stopped
   logic feedback_cascade_sel_ff; // product path chosen
   logic [7:0] rdata_ff; // read data, one cycle after strobe

   // ----------------------------------------------------------------
   // pin synchronisers and edge detect
   // ----------------------------------------------------------------
   logic [1:0] ref_sync_ff; // [0] feeds only [1]
   logic [1:0] vcxo_sync_ff;
   logic ref_prev_ff; // last synchronised level
   logic vcxo_prev_ff;
   logic ref_tick; // rising reference edge
   logic vcxo_tick; // rising vcxo edge

   // two stages before anything reads the pins
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ref_sync_ff <= 2'b00;
         vcxo_sync_ff <= 2'b00;
         ref_prev_ff <= 1'b0;
         vcxo_prev_ff <= 1'b0;
      end else begin
         ref_sync_ff <= {ref_sync_ff[0], i_ref_clk};
         vcxo_sync_ff <= {vcxo_sync_ff[0], i_vcxo_clk};
         ref_prev_ff <= ref_sync_ff[1];
         vcxo_prev_ff <= vcxo_sync_ff[1];
      end
   end

   assign ref_tick = ref_sync_ff[1] && !ref_prev_ff;
   assign vcxo_tick = vcxo_sync_ff[1] && !vcxo_prev_ff;

   // ----------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------
   // each field is stored as written; range is left to software
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         fb_div_primary_ff <= `PFD_RST_FB_DIV;
         feedback_phase_sel_ff <= `PFD_RST_PHASE;
         fb_secondary_powerdown_ff <= `PFD_RST_PD;
      end else if (i_wr && i_addr == `PFD_OFS_FB_HI) begin
         feedback_phase_sel_ff <=
            i_wdata[`PFD_PHASE_MSB:`PFD_PHASE_LSB];
         fb_secondary_powerdown_ff <= i_wdata[`PFD_PD_BIT];
         fb_div_primary_ff[11:8] <= i_wdata[`PFD_HI_NIB_MSB:0];
      end else if (i_wr && i_addr == `PFD_OFS_FB_LO) begin
         fb_div_primary_ff[7:0] <= i_wdata;
      end
   end

   // secondary ratio and cascade select
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         fb_div_secondary_ff <= `PFD_RST_SEC_DIV;
         feedback_cascade_sel_ff <= `PFD_RST_CASCADE;
      end else if (i_wr && i_addr == `PFD_OFS_SEC_LO) begin
         fb_div_secondary_ff[7:0] <= i_wdata;
      end else if (i_wr && i_addr == `PFD_OFS_SEC_HI) begin
         fb_div_secondary_ff[8] <= i_wdata[`PFD_SEC_MSB_BIT];
         feedback_cascade_sel_ff <= i_wdata[`PFD_CASCADE_BIT];
      end
   end

   // reference ratio and its phase select
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ref_predivider_ff <= `PFD_RST_REF_DIV;
         ref_phase_sel_ff <= `PFD_RST_PHASE;
      end else if (i_wr && i_addr == `PFD_OFS_REF_HI) begin
         ref_phase_sel_ff <= i_wdata[`PFD_PHASE_MSB:`PFD_PHASE_LSB];
         ref_predivider_ff[11:8] <= i_wdata[`PFD_HI_NIB_MSB:0];
      end else if (i_wr && i_addr == `PFD_OFS_REF_LO) begin
         ref_predivider_ff[7:0] <= i_wdata;
      end
   end

   // ----------------------------------------------------------------
   // divider instances
   // ----------------------------------------------------------------
   pfd_div_if #(.W(12)) ref_if ();
   pfd_div_if #(.W(12)) prim_if ();
   pfd_div_if #(.W(9)) sec_if ();

   // (RL2) reference predivider on reference edges
   assign ref_if.div_value = ref_predivider_ff;
   assign ref_if.phase_sel = ref_phase_sel_ff;
   assign ref_if.enable = 1'b1;
   assign ref_if.tick = ref_tick;

   // (RL1) primary divider on vcxo edges
   assign prim_if.div_value = fb_div_primary_ff;
   assign prim_if.phase_sel = feedback_phase_sel_ff;
   assign prim_if.enable = 1'b1;
   assign prim_if.tick = vcxo_tick;

   // (RL3) powerdown stops the secondary divider
   assign sec_if.div_value = fb_div_secondary_ff;
   assign sec_if.phase_sel = feedback_phase_sel_ff;
   assign sec_if.enable = !fb_secondary_powerdown_ff;
   assign sec_if.tick = prim_if.out_pulse;

   pfd_divider #(.W(12)) u_ref_div (
      .i_core_clk(i_core_clk),
      .i_nrst(i_nrst),
      .bus(ref_if)
   );

   pfd_divider #(.W(12)) u_prim_div (
      .i_core_clk(i_core_clk),
      .i_nrst(i_nrst),
      .bus(prim_if)
   );

   pfd_divider #(.W(9)) u_sec_div (
      .i_core_clk(i_core_clk),
      .i_nrst(i_nrst),
      .bus(sec_if)
   );

   // ----------------------------------------------------------------
   // feedback selection and lock window
   // ----------------------------------------------------------------
   logic fb_pulse; // selected feedback edge
   logic fb_win; // selected feedback window
   logic ref_pulse_ff;
   logic fb_pulse_ff;
   logic sample_ff;
   logic in_win_ff;

   // (RL8) cascade picks primary times secondary
   assign fb_pulse = feedback_cascade_sel_ff ? sec_if.out_pulse
      : prim_if.out_pulse;
   assign fb_win = feedback_cascade_sel_ff
      ? (sec_if.win_open && prim_if.win_open) : prim_if.win_open;

   // registered divided outputs
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ref_pulse_ff <= 1'b0;
         fb_pulse_ff <= 1'b0;
      end else begin
         ref_pulse_ff <= ref_if.out_pulse;
         fb_pulse_ff <= fb_pulse;
      end
   end

   // (RL7) sample on either edge, both windows
   // a sample is taken at every reference or feedback edge; the
   // result holds until the next sample so slow loops stay visible
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         sample_ff <= 1'b0;
         in_win_ff <= 1'b0;
      end else begin
         sample_ff <= ref_if.out_pulse || fb_pulse;
         if (ref_if.out_pulse || fb_pulse) begin
            in_win_ff <= ref_if.win_open && fb_win;
         end
      end
   end

   // ----------------------------------------------------------------
   // register reads
   // ----------------------------------------------------------------
   // unmapped addresses and reserved bits read as zero
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rdata_ff <= 8'h00;
      end else if (i_rd) begin
         unique case (i_addr)
            `PFD_OFS_FB_HI: rdata_ff <= {feedback_phase_sel_ff,
               fb_secondary_powerdown_ff, fb_div_primary_ff[11:8]};
            `PFD_OFS_FB_LO: rdata_ff <= fb_div_primary_ff[7:0];
            `PFD_OFS_SEC_LO: rdata_ff <= fb_div_secondary_ff[7:0];
            `PFD_OFS_SEC_HI: rdata_ff <= {fb_div_secondary_ff[8],
               6'h00, feedback_cascade_sel_ff};
            `PFD_OFS_REF_HI: rdata_ff <= {ref_phase_sel_ff, 1'b0,
               ref_predivider_ff[11:8]};
            `PFD_OFS_REF_LO: rdata_ff <= ref_predivider_ff[7:0];
            `PFD_OFS_STATUS: rdata_ff <= {5'h00, sec_if.enable,
               fb_win, in_win_ff};
            default: rdata_ff <= 8'h00;
         endcase
      end else begin
         // data stand only in the cycle after the strobe
         rdata_ff <= 8'h00;
      end
   end

   assign o_rdata = rdata_ff;
   assign o_ref_div_pulse = ref_pulse_ff;
   assign o_fb_div_pulse = fb_pulse_ff;
   assign o_lock_sample = sample_ff;
   assign o_lock_in_window = in_win_ff;
endmodule

// *** src/pfd_consts.svh ***
// constants for the first-stage pll reference and feedback dividers
// assumes an 8-bit register port with byte addresses as below
// How it works
// (RL1) primary divides 1..4095, secondary 4..511
// (RL2) reference predivider divides by 1..4095
// (RL3) powerdown bit set stops secondary divider
// (RL4) software powers down unused secondary divider
// (RL5) software matches feedback phase select range
// (RL6) software matches reference phase select range
// (RL7) both phase selects set lock window
// (RL8) cascade bit picks primary or product
`ifndef PFD_CONSTS_SVH
`define PFD_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PFD_OFS_FB_HI 8'h00
`define PFD_OFS_FB_LO 8'h01
`define PFD_OFS_SEC_LO 8'h02
`define PFD_OFS_SEC_HI 8'h03
`define PFD_OFS_REF_HI 8'h04
`define PFD_OFS_REF_LO 8'h05
`define PFD_OFS_STATUS 8'h06

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PFD_PHASE_MSB 7
`define PFD_PHASE_LSB 5
`define PFD_PD_BIT 4
`define PFD_HI_NIB_MSB 3
`define PFD_SEC_MSB_BIT 7
`define PFD_CASCADE_BIT 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PFD_RST_FB_DIV 12'hc00
`define PFD_RST_REF_DIV 12'hc00
`define PFD_RST_SEC_DIV 9'h060
`define PFD_RST_PHASE 3'h0
`define PFD_RST_PD 1'b0
`define PFD_RST_CASCADE 1'b0

`endif

// *** src/pfd_pkg.sv ***
// types shared by the divider block
// assumes the constants header supplies widths' reset values
package pfd_pkg;
   // divider field widths
   typedef logic [11:0] pfd_div12_t;
   typedef logic [8:0] pfd_div9_t;
   typedef logic [2:0] pfd_phase_t;
endpackage

// *** src/pfd_div_if.sv ***
// signals between the block top and one divider instance
// assumes a single core clock drives both ends
`timescale 1ns/1ps
interface pfd_div_if #(parameter int W = 12);
   logic [W-1:0] div_value; // programmed divide ratio
   logic [2:0] phase_sel; // lock sampling window select
   logic enable; // divider running
   logic tick; // one input edge, one cycle pulse
   logic out_pulse; // one cycle pulse per divided period
   logic win_open; // count lies inside the lock window
   modport ctl(output div_value, phase_sel, enable, tick,
      input out_pulse, win_open);
   modport div(input div_value, phase_sel, enable, tick,
      output out_pulse, win_open);
endinterface

// *** src/pfd_divider.sv ***
// one programmable edge-count divider with a lock window flag
// assumes tick is already synchronous to the core clock
`timescale 1ns/1ps
module pfd_divider #(
   parameter int W = 12
) (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   pfd_div_if.div bus
);
   // ----------------------------------------------------------------
   // count state
   // ----------------------------------------------------------------
   logic [W-1:0] cnt_ff; // edges since last terminal count
   logic pulse_ff; // registered divided output
   logic [W-1:0] last; // terminal count value
   logic [W-1:0] width; // window half width in input edges

   // a zero ratio is illegal; run it as divide by one
   assign last = (bus.div_value == '0) ? '0 : bus.div_value - W'(1);
   assign width = W'(1) << bus.phase_sel;

   // (RL1) count input edges
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt_ff <= '0;
      end else if (!bus.enable) begin
         // held at zero while stopped so restart is clean
         cnt_ff <= '0;
      end else if (bus.tick) begin
         cnt_ff <= (cnt_ff >= last) ? '0 : cnt_ff + W'(1);
      end
   end

   // one output pulse at each terminal count
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         pulse_ff <= 1'b0;
      end else begin
         pulse_ff <= bus.enable && bus.tick && (cnt_ff >= last);
      end
   end

   // (RL7) window straddles the divider edge
   always_comb begin
      if (!bus.enable) begin
         bus.win_open = 1'b0;
      end else if ({1'b0, bus.div_value} <= {1'b0, width}) begin
         // short ratio: the whole period counts as inside
         bus.win_open = 1'b1;
      end else begin
         bus.win_open = (cnt_ff < width) ||
            (cnt_ff >= bus.div_value - width);
      end
   end

   assign bus.out_pulse = pulse_ff;
endmodule

// *** verif/pfd_clk_src.sv ***
// clock source model for the reference and vcxo pins
// assumes half periods in core cycles; zero parks the pin low
`timescale 1ns/1ps
module pfd_clk_src (
   input wire logic i_core_clk,
   input wire logic [7:0] i_ref_half,
   input wire logic [7:0] i_vcxo_half,
   output logic o_ref_clk,
   output logic o_vcxo_clk
);
   logic [7:0] half [2]; // requested half periods
   logic [7:0] cnt [2]; // cycles into the current half period
   logic [1:0] clk_q; // pin levels
   assign half[0] = i_ref_half;
   assign half[1] = i_vcxo_half;
   assign o_ref_clk = clk_q[0];
   assign o_vcxo_clk = clk_q[1];
   initial begin
      cnt = '{8'h00, 8'h00};
      clk_q = 2'h0;
   end
   // pins move right after a core edge, never between, so that
   // the checker's edge ages stay exact
   always @(posedge i_core_clk) begin
      for (int k = 0; k < 2; k++) begin
         if (half[k] == 8'h00) begin
            clk_q[k] <= 1'b0;
            cnt[k] <= 8'h00;
         end else if (cnt[k] + 8'h01 >= half[k]) begin
            clk_q[k] <= !clk_q[k];
            cnt[k] <= 8'h00;
         end else begin
            cnt[k] <= cnt[k] + 8'h01;
         end
      end
   end
endmodule

// *** verif/pfd_top_sva.sv ***
// port checker for the divider block, bound into pfd_top
// assumes pins are slow against the core clock
`timescale 1ns/1ps
module pfd_top_sva (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] o_rdata,
   input wire logic i_ref_clk,
   input wire logic i_vcxo_clk,
   input wire logic o_ref_div_pulse,
   input wire logic o_fb_div_pulse,
   input wire logic o_lock_sample,
   input wire logic o_lock_in_window
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);
   // ----------------------------------------
   // helper: register mirror and pin edge ages
   // ----------------------------------------
   logic [7:0] mir_ff [6]; // writable bits of bytes 00..05
   logic [7:0] exp_ff; // expected read byte
   logic chk_ff; // a checked read is answering
   logic ref_d_ff, fb_d_ff; // pin levels one cycle ago
   logic [7:0] ref_age_ff, fb_age_ff; // cycles since a pin rose
   function automatic logic [7:0] msk(input logic [7:0] a);
      return a == 8'h03 ? 8'h81 : (a == 8'h04 ? 8'hef : 8'hff);
   endfunction
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         mir_ff <= '{8'h0c, 8'h00, 8'h60, 8'h00, 8'h0c, 8'h00};
      end else if (i_wr && i_addr < 8'h06) begin
         mir_ff[i_addr[2:0]] <= i_wdata & msk(i_addr);
      end
   end
   // status byte is skipped: it depends on live counts
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         exp_ff <= 8'h00;
         chk_ff <= 1'b0;
      end else begin
         exp_ff <= i_addr < 8'h06 ? mir_ff[i_addr[2:0]] : 8'h00;
         chk_ff <= i_rd && i_addr != 8'h06;
      end
   end
   // ages saturate so a stopped pin cannot wrap into range
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ref_d_ff <= 1'b0;
         fb_d_ff <= 1'b0;
         ref_age_ff <= 8'hff;
         fb_age_ff <= 8'hff;
      end else begin
         ref_d_ff <= i_ref_clk;
         fb_d_ff <= i_vcxo_clk;
         ref_age_ff <= (i_ref_clk && !ref_d_ff) ? 8'h00 :
            ref_age_ff + {7'h00, ref_age_ff != 8'hff};
         fb_age_ff <= (i_vcxo_clk && !fb_d_ff) ? 8'h00 :
            fb_age_ff + {7'h00, fb_age_ff != 8'hff};
      end
   end
   AST_RD_DATA: assert property (chk_ff |-> o_rdata == exp_ff)
      else $error("read data differs from mirror");
   AST_RD_IDLE: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data outside a read answer");
   AST_REF_ONE: assert property (o_ref_div_pulse |=> !o_ref_div_pulse)
      else $error("reference pulse longer than one cycle");
   AST_FB_ONE: assert property (o_fb_div_pulse |=> !o_fb_div_pulse)
      else $error("feedback pulse longer than one cycle");
   AST_REF_LAT: assert property (
      o_ref_div_pulse |-> ref_age_ff inside {[2:7]})
      else $error("reference pulse not tied to a pin edge");
   AST_FB_LAT: assert property (
      o_fb_div_pulse |-> fb_age_ff inside {[2:7]})
      else $error("feedback pulse not tied to a pin edge");
   AST_SAMPLE: assert property (o_ref_div_pulse |-> o_lock_sample)
      else $error("no lock sample at reference edge");
   AST_WIN_HOLD: assert property (
      $changed(o_lock_in_window) |-> o_lock_sample || $past(o_lock_sample))
      else $error("window result moved without a sample");
   AST_PD_QUIET: assert property (
      (mir_ff[0][4] && mir_ff[3][0]) [*4] |-> !o_fb_div_pulse)
      else $error("feedback pulse while secondary is down");
   cover property (o_fb_div_pulse && mir_ff[3][0]);
   cover property ($rose(o_lock_in_window));
   cover property (o_ref_div_pulse);
endmodule
bind pfd_top pfd_top_sva u_sva (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
   .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
   .o_rdata(o_rdata), .i_ref_clk(i_ref_clk), .i_vcxo_clk(i_vcxo_clk),
   .o_ref_div_pulse(o_ref_div_pulse), .o_fb_div_pulse(o_fb_div_pulse),
   .o_lock_sample(o_lock_sample), .o_lock_in_window(o_lock_in_window));

// *** verif/tb.sv ***
// self-checking bench for the divider block
// assumes the clock source model drives both pins
`timescale 1ns/1ps
module tb;
   logic i_core_clk, i_nrst, i_wr, i_rd;
   logic [7:0] i_addr, i_wdata, o_rdata, d, rh, vh;
   logic rclk, vclk, rp, fp, ls, lw;
   int fails = 0;
   int checks_done = 0;
   int n;
   // reset values and writable bits of bytes 00..05
   logic [7:0] rst_v [6] = '{8'h0c, 8'h00, 8'h60, 8'h00, 8'h0c, 8'h00};
   logic [7:0] msk_v [6] = '{8'hff, 8'hff, 8'hff, 8'h81, 8'hef, 8'hff};
   pfd_top u_dut (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(o_rdata), .i_ref_clk(rclk), .i_vcxo_clk(vclk),
      .o_ref_div_pulse(rp), .o_fb_div_pulse(fp),
      .o_lock_sample(ls), .o_lock_in_window(lw));
   pfd_clk_src u_src (.i_core_clk(i_core_clk), .i_ref_half(rh),
      .i_vcxo_half(vh), .o_ref_clk(rclk), .o_vcxo_clk(vclk));
   initial begin
      i_core_clk = 1'b0;
      forever #2.5 i_core_clk = ~i_core_clk;
   end
   // ----------------------------------------
   // bus cycles and comparison
   // ----------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge i_core_clk);
      i_addr <= a;
      i_wdata <= v;
      i_wr <= 1'b1;
      @(posedge i_core_clk);
      i_wr <= 1'b0;
   endtask
   // answer stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge i_core_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_core_clk);
      i_rd <= 1'b0;
      @(negedge i_core_clk);
      v = o_rdata;
   endtask
   // cycles between two pulses; a missing pulse gives 4000
   task automatic gap(input logic fb, output int c);
      int w;
      w = 0;
      while ((fb ? fp : rp) !== 1'b1 && w < 4000) begin
         @(negedge i_core_clk);
         w++;
      end
      c = 0;
      do begin
         @(negedge i_core_clk);
         c++;
      end while ((fb ? fp : rp) !== 1'b1 && c < 4000);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_regs;
      for (int i = 0; i < 6; i++) begin
         rd(i[7:0], d);
         chk(d, rst_v[i]);
         wr(i[7:0], 8'hff);
         rd(i[7:0], d);
         chk(d, msk_v[i]);
         wr(i[7:0], rst_v[i]);
      end
      rd(8'h07, d);
      chk(d, 8'h00);
   endtask
   task automatic t_phase;
      for (int p = 0; p < 8; p++) begin
         wr(8'h00, {p[2:0], 5'h0c});
         wr(8'h04, {p[2:0], 5'h0c});
         rd(8'h00, d);
         chk(d, {p[2:0], 5'h0c});
         rd(8'h04, d);
         chk(d, {p[2:0], 5'h0c});
      end
   endtask
   // high nibble and low byte join into one ratio
   task automatic t_ref;
      wr(8'h04, 8'h01);
      wr(8'h05, 8'h03);
      gap(1'b0, n);
      gap(1'b0, n);
      chk(n[15:0], 16'h0818);
      wr(8'h05, 8'h01);
      wr(8'h04, 8'h00);
      gap(1'b0, n);
      gap(1'b0, n);
      chk(n[15:0], 16'h0008);
   endtask
   task automatic t_fb;
      int q;
      wr(8'h00, 8'h00);
      wr(8'h01, 8'h05);
      gap(1'b1, n);
      gap(1'b1, n);
      chk(n[15:0], 16'h0028);
      wr(8'h02, 8'h04);
      wr(8'h03, 8'h01);
      gap(1'b1, n);
      gap(1'b1, n);
      chk(n[15:0], 16'h00a0);
      wr(8'h00, 8'h10);
      repeat (4) @(negedge i_core_clk);
      q = 0;
      repeat (300) begin
         @(negedge i_core_clk);
         q += (fp === 1'b1);
      end
      chk(q[15:0], 16'h0000);
      // status bit 2 reports the secondary divider running
      rd(8'h06, d);
      chk({15'h0000, d[2]}, 16'h0000);
      wr(8'h00, 8'h00);
      gap(1'b1, n);
      gap(1'b1, n);
      chk(n[15:0], 16'h00a0);
      rd(8'h06, d);
      chk({15'h0000, d[2]}, 16'h0001);
   endtask
   // reference and vcxo edges coincide; one edge after a feedback
   // pulse the primary count is 1, closed for a narrow window but
   // open when the widest windows cover the whole small ratio
   task automatic t_lock;
      wr(8'h03, 8'h00);
      gap(1'b1, n);
      chk({15'h0000, ls}, 16'h0001);
      repeat (12) @(negedge i_core_clk);
      chk({15'h0000, lw}, 16'h0000);
      wr(8'h00, 8'he0);
      wr(8'h04, 8'he0);
      gap(1'b1, n);
      gap(1'b1, n);
      repeat (12) @(negedge i_core_clk);
      chk({15'h0000, lw}, 16'h0001);
   endtask
   task automatic stop_test;
      $display("checks_done=%0d fails=%0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #300us;
      fails++;
      stop_test;
   end
   initial begin
      i_nrst = 1'b0;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_addr = 8'h00;
      i_wdata = 8'h00;
      rh = 8'h04;
      vh = 8'h04;
      repeat (8) @(posedge i_core_clk);
      i_nrst <= 1'b1;
      t_regs;
      t_phase;
      t_ref;
      t_fb;
      t_lock;
      stop_test;
   end
endmodule
